// ==== hdl/aoc_pkg.sv ====
// constants, register map and types for the adc output and interleave control block
//
// Overview of operation
// - ddr parallel bus, lvds default, cmos selectable
// - lvds drive current nominal or power saving
// - output mode chosen by write at 0x73
// - nap or sleep floats data, clock, over-range
// - three-level pin picks normal, sleep, nap
// - software power setting overrides the pin
// - nap exit waits relock if clock stopped
// - three codings, twos complement default, at 0x73
// - offset binary: zeros lowest, ones highest
// - twos complement inverts only the msb
// - gray: msb kept, lower bits xor neighbour
// - engine off at reset, run by command
// - track only while out-of-notch power suffices
// - exclude narrow band around odd quarter rates
// - criteria lost: hold and freeze corrections
// - criteria back: resume tracking by itself
// - full performance after one second tracking
// - ac and total power, own threshold, hysteresis
// - notch feeds estimator only, can power down
// - thresholds, status, initial corrections host accessible
package aoc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_OUT_CFG   = 10'h073;
  localparam logic [9:0] IDX_PWR_CTL   = 10'h074;
  localparam logic [9:0] IDX_ENG_CTL   = 10'h075;
  localparam logic [9:0] IDX_AC_THR    = 10'h076;
  localparam logic [9:0] IDX_TOT_THR   = 10'h077;
  localparam logic [9:0] IDX_NOTCH_THR = 10'h078;
  localparam logic [9:0] IDX_INIT_CORR = 10'h079;
  localparam logic [9:0] IDX_STATUS    = 10'h07A;
  localparam logic [9:0] IDX_LEVELS    = 10'h07B;
  localparam logic [9:0] IDX_CORR      = 10'h07C;
  localparam logic [9:0] IDX_NOTCH_LVL = 10'h07D;
  // field positions
  localparam int unsigned CFG_CODING_LSB = 0;
  localparam int unsigned CFG_CMOS_BIT   = 4;
  localparam int unsigned CFG_LOWI_BIT   = 5;
  localparam int unsigned ENG_RUN_BIT    = 0;
  localparam int unsigned ENG_NPD_BIT    = 1;
  localparam int unsigned HYST_LSB       = 16;
  // coding field values
  localparam logic [1:0] COD_OFFSET = 2'h0;
  localparam logic [1:0] COD_TWOS   = 2'h1;
  localparam logic [1:0] COD_GRAY   = 2'h2;
  // power field values
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_NAP    = 2'h1;
  localparam logic [1:0] PWR_SLEEP  = 2'h2;
  // reset values
  localparam logic [31:0] RST_OUT_CFG   = 32'h0000_0001;
  localparam logic [31:0] RST_ENG_CTL   = 32'h0000_0000;
  localparam logic [31:0] RST_THR       = 32'h0010_0100;
  localparam logic [31:0] RST_NOTCH_THR = 32'h0000_0400;
  localparam logic [31:0] RST_INIT_CORR = 32'h0000_0000;
  // times and cycle counts
  localparam int unsigned RELOCK_US     = 52;
  localparam int unsigned RELOCK_CYC    = RELOCK_US * CLK_MHZ;
  localparam int unsigned WAKE_CYC      = 16;
  localparam int unsigned PERF_MS       = 1000;
  localparam int unsigned PERF_CYC      = PERF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BRIEF_US      = 10;
  localparam int unsigned BRIEF_CYC     = BRIEF_US * CLK_MHZ;
  localparam int unsigned WIN_LOG       = 8;
  localparam logic [31:0] PERF_CYC_32   = 32'(PERF_CYC);
  typedef enum logic [1:0] {ENG_OFF, ENG_TRACK, ENG_HOLD} aoc_eng_e;
endpackage : aoc_pkg

// ==== hdl/aoc_ctrl.sv ====
// adc output coding, ddr output bus, power states and interleave correction control
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl #(
  parameter int unsigned RELOCK_CYCLES = aoc_pkg::RELOCK_CYC,
  parameter logic [31:0] PERF_CYCLES   = aoc_pkg::PERF_CYC_32
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // converter core samples, offset binary, same clock
  input  wire logic [11:0] sample_in,
  input  wire logic        sample_valid_in,
  input  wire logic        over_range_in,
  // three-level power pin sensed as two comparators, and clock-loss flag
  input  wire logic        power_state_select_pin_high_in,
  input  wire logic        power_state_select_pin_low_in,
  input  wire logic        clock_lost_in,
  // ddr output bus
  output logic      [5:0]  data_out,
  output logic             data_oe_n_out,
  output logic             output_data_clock_out,
  output logic             output_data_clock_oe_n_out,
  output logic             over_range_out,
  output logic             over_range_oe_n_out,
  output logic             cmos_mode_out,
  output logic             lvds_low_current_out,
  // engine corrections applied to the core
  output logic      [7:0]  corr_offset_out,
  output logic      [7:0]  corr_gain_out,
  output logic      [7:0]  corr_timing_out,
  output logic             notch_powered_out,
  output logic             perf_ok_out
);
  localparam int unsigned WL = aoc_pkg::WIN_LOG;

  logic [31:0] out_cfg_ff, eng_ctl_ff, ac_thr_ff, tot_thr_ff, notch_thr_ff, init_corr_ff;
  logic [1:0]  pwr_sw_ff;
  logic        pwr_sw_set_ff;
  logic [1:0]  pin_mode_ff;
  logic [2:0]  pin_hi_sync_ff, pin_lo_sync_ff, lost_sync_ff;
  logic [1:0]  pwr_state_ff;
  logic        lost_seen_ff;
  logic [15:0] wake_cnt_ff;
  logic        waking_ff;
  aoc_pkg::aoc_eng_e eng_ff, nxt_eng;
  logic [11:0] ac_lvl_ff, tot_lvl_ff, notch_lvl_ff;
  logic        ac_ok_ff, tot_ok_ff, notch_hot_ff;
  logic [7:0]  c_off_ff, c_gain_ff, c_tim_ff;
  logic [31:0] perf_cnt_ff;
  logic        perf_done_ff;
  logic [11:0] bad_cnt_ff;

  // apb access decode
  wire         acc      = psel_in & penable_in;
  wire         wr       = acc & pwrite_in;
  wire  [9:0]  idx      = paddr_in[11:2];
  wire         aligned  = (paddr_in[1:0] == 2'b00);
  logic        mapped;
  always_comb
  begin
    case (idx)
      aoc_pkg::IDX_OUT_CFG, aoc_pkg::IDX_PWR_CTL, aoc_pkg::IDX_ENG_CTL,
      aoc_pkg::IDX_AC_THR, aoc_pkg::IDX_TOT_THR, aoc_pkg::IDX_NOTCH_THR,
      aoc_pkg::IDX_INIT_CORR, aoc_pkg::IDX_STATUS, aoc_pkg::IDX_LEVELS,
      aoc_pkg::IDX_CORR, aoc_pkg::IDX_NOTCH_LVL: mapped = aligned;
      default:                                   mapped = 1'b0;
    endcase
  end
  wire wr_ok = wr & mapped;

  // writable registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      out_cfg_ff   <= aoc_pkg::RST_OUT_CFG;
      eng_ctl_ff   <= aoc_pkg::RST_ENG_CTL;
      ac_thr_ff    <= aoc_pkg::RST_THR;
      tot_thr_ff   <= aoc_pkg::RST_THR;
      notch_thr_ff <= aoc_pkg::RST_NOTCH_THR;
      init_corr_ff <= aoc_pkg::RST_INIT_CORR;
    end
    else if (wr_ok)
    begin
      case (idx)
        aoc_pkg::IDX_OUT_CFG:   out_cfg_ff   <= pwdata_in & 32'h0000_0033;
        aoc_pkg::IDX_ENG_CTL:   eng_ctl_ff   <= pwdata_in & 32'h0000_0003;
        aoc_pkg::IDX_AC_THR:    ac_thr_ff    <= pwdata_in & 32'h0FFF_0FFF;
        aoc_pkg::IDX_TOT_THR:   tot_thr_ff   <= pwdata_in & 32'h0FFF_0FFF;
        aoc_pkg::IDX_NOTCH_THR: notch_thr_ff <= pwdata_in & 32'h0000_0FFF;
        aoc_pkg::IDX_INIT_CORR: init_corr_ff <= pwdata_in & 32'h00FF_FFFF;
        default:                ;
      endcase
    end
  end

  // software power setting; once written it owns the power state
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_sw_ff     <= aoc_pkg::PWR_NORMAL;
      pwr_sw_set_ff <= 1'b0;
    end
    else if (wr_ok && idx == aoc_pkg::IDX_PWR_CTL)
    begin
      pwr_sw_ff     <= (pwdata_in[1:0] == 2'b11) ? aoc_pkg::PWR_NORMAL : pwdata_in[1:0];
      pwr_sw_set_ff <= 1'b1;
    end
  end

  // pin synchronisers: stage 0 only feeds stage 1
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_hi_sync_ff <= 3'b000;
      pin_lo_sync_ff <= 3'b111;
      lost_sync_ff   <= 3'b000;
    end
    else
    begin
      pin_hi_sync_ff <= {pin_hi_sync_ff[1:0], power_state_select_pin_high_in};
      pin_lo_sync_ff <= {pin_lo_sync_ff[1:0], power_state_select_pin_low_in};
      lost_sync_ff   <= {lost_sync_ff[1:0], clock_lost_in};
    end
  end

  // low gives normal, high gives nap, neither (floating) gives sleep
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pin_mode_ff <= aoc_pkg::PWR_NORMAL;
    else if (pin_hi_sync_ff[1] == pin_hi_sync_ff[2] && pin_lo_sync_ff[1] == pin_lo_sync_ff[2])
    begin
      if (pin_lo_sync_ff[2])
        pin_mode_ff <= aoc_pkg::PWR_NORMAL;
      else if (pin_hi_sync_ff[2])
        pin_mode_ff <= aoc_pkg::PWR_NAP;
      else
        pin_mode_ff <= aoc_pkg::PWR_SLEEP;
    end
  end

  wire [1:0] want_pwr = pwr_sw_set_ff ? pwr_sw_ff : pin_mode_ff;
  wire       lost_st  = lost_sync_ff[1] & lost_sync_ff[2];

  // power state with wake-up delay; a stopped clock in nap means dll relock
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_state_ff <= aoc_pkg::PWR_NORMAL;
      lost_seen_ff <= 1'b0;
      wake_cnt_ff  <= 16'h0000;
      waking_ff    <= 1'b0;
    end
    else
    begin
      if (want_pwr != aoc_pkg::PWR_NORMAL)
      begin
        pwr_state_ff <= want_pwr;
        waking_ff    <= 1'b0;
        if (want_pwr == aoc_pkg::PWR_NAP && lost_st)
          lost_seen_ff <= 1'b1;
      end
      else if (pwr_state_ff != aoc_pkg::PWR_NORMAL && !waking_ff)
      begin
        waking_ff   <= 1'b1;
        wake_cnt_ff <= (pwr_state_ff == aoc_pkg::PWR_NAP && lost_seen_ff)
                       ? 16'(RELOCK_CYCLES - 1) : 16'(aoc_pkg::WAKE_CYC - 1);
      end
      else if (waking_ff)
      begin
        if (wake_cnt_ff == 16'h0000)
        begin
          waking_ff    <= 1'b0;
          pwr_state_ff <= aoc_pkg::PWR_NORMAL;
          lost_seen_ff <= 1'b0;
        end
        else
          wake_cnt_ff <= wake_cnt_ff - 16'h0001;
      end
    end
  end

  wire active = (pwr_state_ff == aoc_pkg::PWR_NORMAL);

  // output coding from offset binary
  logic [11:0] coded;
  always_comb
  begin
    case (out_cfg_ff[aoc_pkg::CFG_CODING_LSB +: 2])
      aoc_pkg::COD_OFFSET: coded = sample_in;
      aoc_pkg::COD_GRAY:   coded = sample_in ^ {1'b0, sample_in[11:1]};
      default:             coded = {~sample_in[11], sample_in[10:0]};
    endcase
  end

  // ddr bus: clock toggles each cycle, high half word while clock low, low half while high
  logic [11:0] word_ff;
  logic        clk_ph_ff, or_ff;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      word_ff   <= 12'h000;
      or_ff     <= 1'b0;
      clk_ph_ff <= 1'b0;
    end
    else
    begin
      clk_ph_ff <= ~clk_ph_ff;
      if (sample_valid_in)
      begin
        word_ff <= coded;
        or_ff   <= over_range_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_out                   <= 6'h00;
      data_oe_n_out              <= 1'b1;
      output_data_clock_out      <= 1'b0;
      output_data_clock_oe_n_out <= 1'b1;
      over_range_out             <= 1'b0;
      over_range_oe_n_out        <= 1'b1;
      cmos_mode_out              <= 1'b0;
      lvds_low_current_out       <= 1'b0;
    end
    else
    begin
      data_out                   <= clk_ph_ff ? word_ff[5:0] : word_ff[11:6];
      output_data_clock_out      <= clk_ph_ff;
      over_range_out             <= or_ff;
      data_oe_n_out              <= ~active;
      output_data_clock_oe_n_out <= ~active;
      over_range_oe_n_out        <= ~active;
      cmos_mode_out              <= out_cfg_ff[aoc_pkg::CFG_CMOS_BIT];
      lvds_low_current_out       <= out_cfg_ff[aoc_pkg::CFG_LOWI_BIT];
    end
  end

  // estimator path: signed samples, notch y = (x + x[n-2]) / 2 nulls odd quarter rates
  wire signed [11:0] xs = {~sample_in[11], sample_in[10:0]};
  logic signed [11:0] xz1_ff, xz2_ff, yz_ff;
  wire  notch_on = ~eng_ctl_ff[aoc_pkg::ENG_NPD_BIT];
  wire  signed [12:0] nsum  = 13'(xs) + 13'(xz2_ff);
  wire  signed [12:0] ndif  = 13'(xs) - 13'(xz2_ff);
  wire  signed [11:0] y     = notch_on ? 12'(nsum >>> 1) : xs;
  wire  [11:0]        nmag  = ndif[12] ? 12'((-ndif) >> 1) : 12'(ndif >> 1);
  wire  [11:0]        ymag  = y[11] ? 12'(-y) : 12'(y);
  wire  signed [12:0] ydif  = 13'(y) - 13'(yz_ff);
  wire  [11:0]        dmag  = ydif[12] ? 12'((-ydif) >> 1) : 12'(ydif >> 1);
  logic signed [11:0] mean_ff;
  wire  signed [12:0] acd   = 13'(y) - 13'(mean_ff);
  wire  [11:0]        acmag = acd[12] ? 12'((-acd) >> 1) : 12'(acd >> 1);

  logic [WL-1:0]      win_ff;
  logic [19:0]        ac_acc_ff, tot_acc_ff, n_acc_ff;
  logic signed [19:0] mean_acc_ff, off_acc_ff, gain_acc_ff, tim_acc_ff;
  logic               par_ff;
  wire                win_end = sample_valid_in & (&win_ff);
  wire                tracking = (eng_ff == aoc_pkg::ENG_TRACK);

  // power meter and mismatch statistics, windowed over 2^WL samples
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      xz1_ff <= 12'sh000; xz2_ff <= 12'sh000; yz_ff <= 12'sh000; mean_ff <= 12'sh000;
      win_ff <= '0; par_ff <= 1'b0;
      ac_acc_ff <= 20'h0_0000; tot_acc_ff <= 20'h0_0000; n_acc_ff <= 20'h0_0000;
      mean_acc_ff <= 20'sh0_0000; off_acc_ff <= 20'sh0_0000;
      gain_acc_ff <= 20'sh0_0000; tim_acc_ff <= 20'sh0_0000;
      ac_lvl_ff <= 12'h000; tot_lvl_ff <= 12'h000; notch_lvl_ff <= 12'h000;
    end
    else if (sample_valid_in)
    begin
      xz1_ff <= xs;
      xz2_ff <= xz1_ff;
      yz_ff  <= y;
      par_ff <= ~par_ff;
      win_ff <= win_ff + 1'b1;
      if (win_end)
      begin
        ac_lvl_ff    <= 12'((ac_acc_ff + 20'(acmag)) >> WL);
        tot_lvl_ff   <= 12'((tot_acc_ff + 20'(ymag)) >> WL);
        notch_lvl_ff <= notch_on ? 12'((n_acc_ff + 20'(nmag)) >> WL) : 12'h000;
        mean_ff      <= 12'((mean_acc_ff + 20'(y)) >>> WL);
        ac_acc_ff <= 20'h0_0000; tot_acc_ff <= 20'h0_0000; n_acc_ff <= 20'h0_0000;
        mean_acc_ff <= 20'sh0_0000; off_acc_ff <= 20'sh0_0000;
        gain_acc_ff <= 20'sh0_0000; tim_acc_ff <= 20'sh0_0000;
      end
      else
      begin
        ac_acc_ff   <= ac_acc_ff + 20'(acmag);
        tot_acc_ff  <= tot_acc_ff + 20'(ymag);
        n_acc_ff    <= n_acc_ff + 20'(nmag);
        mean_acc_ff <= mean_acc_ff + 20'(y);
        // even core minus odd core
        off_acc_ff  <= par_ff ? off_acc_ff - 20'(y) : off_acc_ff + 20'(y);
        gain_acc_ff <= par_ff ? gain_acc_ff - 20'(ymag) : gain_acc_ff + 20'(ymag);
        tim_acc_ff  <= par_ff ? tim_acc_ff - 20'(dmag) : tim_acc_ff + 20'(dmag);
      end
    end
  end

  // threshold compare with hysteresis: set at or above threshold, clear below threshold - hyst
  function automatic logic meter_ok(input logic old, input logic [11:0] lvl,
                                    input logic [31:0] thr);
    logic [12:0] low;
    low = 13'(thr[11:0]) - 13'(thr[aoc_pkg::HYST_LSB +: 12]);
    if (13'(lvl) >= 13'(thr[11:0]))
      meter_ok = 1'b1;
    else if (low[12] || 13'(lvl) < low)
      meter_ok = 1'b0;
    else
      meter_ok = old;
  endfunction : meter_ok

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ac_ok_ff     <= 1'b0;
      tot_ok_ff    <= 1'b0;
      notch_hot_ff <= 1'b0;
    end
    else
    begin
      ac_ok_ff     <= meter_ok(ac_ok_ff, ac_lvl_ff, ac_thr_ff);
      tot_ok_ff    <= meter_ok(tot_ok_ff, tot_lvl_ff, tot_thr_ff);
      notch_hot_ff <= notch_lvl_ff >= notch_thr_ff[11:0];
    end
  end

  // brief criteria loss is ridden through before hold
  wire criteria = ac_ok_ff & tot_ok_ff;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bad_cnt_ff <= 12'h000;
    else if (criteria || !tracking)
      bad_cnt_ff <= 12'h000;
    else if (bad_cnt_ff != 12'(aoc_pkg::BRIEF_CYC))
      bad_cnt_ff <= bad_cnt_ff + 12'h001;
  end

  always_comb
  begin
    nxt_eng = eng_ff;
    case (eng_ff)
      aoc_pkg::ENG_OFF:   if (eng_ctl_ff[aoc_pkg::ENG_RUN_BIT])
                            nxt_eng = criteria ? aoc_pkg::ENG_TRACK : aoc_pkg::ENG_HOLD;
      aoc_pkg::ENG_TRACK: if (bad_cnt_ff == 12'(aoc_pkg::BRIEF_CYC))
                            nxt_eng = aoc_pkg::ENG_HOLD;
      aoc_pkg::ENG_HOLD:  if (criteria)
                            nxt_eng = aoc_pkg::ENG_TRACK;
      default:            nxt_eng = aoc_pkg::ENG_OFF;
    endcase
    if (!eng_ctl_ff[aoc_pkg::ENG_RUN_BIT])
      nxt_eng = aoc_pkg::ENG_OFF;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      eng_ff <= aoc_pkg::ENG_OFF;
    else
      eng_ff <= nxt_eng;
  end

  // one signed step toward balance per window, saturating
  function automatic logic [7:0] nudge(input logic [7:0] c, input logic signed [19:0] a);
    if (a > 20'sd0 && c != 8'h7F)
      nudge = c + 8'h01;
    else if (a < 20'sd0 && c != 8'h80)
      nudge = c - 8'h01;
    else
      nudge = c;
  endfunction : nudge

  // corrections load on start, move only while tracking, freeze in hold
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      c_off_ff  <= 8'h00;
      c_gain_ff <= 8'h00;
      c_tim_ff  <= 8'h00;
    end
    else if (eng_ff == aoc_pkg::ENG_OFF)
    begin
      c_off_ff  <= init_corr_ff[7:0];
      c_gain_ff <= init_corr_ff[15:8];
      c_tim_ff  <= init_corr_ff[23:16];
    end
    else if (tracking && win_end)
    begin
      c_off_ff  <= nudge(c_off_ff, off_acc_ff);
      c_gain_ff <= nudge(c_gain_ff, gain_acc_ff);
      c_tim_ff  <= nudge(c_tim_ff, tim_acc_ff);
    end
  end

  // cumulative track time since reset; performance holds only while tracking
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      perf_cnt_ff  <= 32'h0000_0000;
      perf_done_ff <= 1'b0;
    end
    else if (tracking && !perf_done_ff)
    begin
      perf_cnt_ff <= perf_cnt_ff + 32'h0000_0001;
      if (perf_cnt_ff == PERF_CYCLES - 32'h0000_0001)
        perf_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      corr_offset_out   <= 8'h00;
      corr_gain_out     <= 8'h00;
      corr_timing_out   <= 8'h00;
      notch_powered_out <= 1'b0;
      perf_ok_out       <= 1'b0;
    end
    else
    begin
      corr_offset_out   <= c_off_ff;
      corr_gain_out     <= c_gain_ff;
      corr_timing_out   <= c_tim_ff;
      notch_powered_out <= notch_on;
      perf_ok_out       <= perf_done_ff & tracking;
    end
  end

  // read mux
  logic [1:0]  eng_code;
  logic [31:0] rdata;
  always_comb
  begin
    case (eng_ff)
      aoc_pkg::ENG_TRACK: eng_code = 2'h1;
      aoc_pkg::ENG_HOLD:  eng_code = 2'h2;
      default:            eng_code = 2'h0;
    endcase
    case (idx)
      aoc_pkg::IDX_OUT_CFG:   rdata = out_cfg_ff;
      aoc_pkg::IDX_PWR_CTL:   rdata = {29'h0000_0000, pwr_sw_set_ff, pwr_sw_ff};
      aoc_pkg::IDX_ENG_CTL:   rdata = eng_ctl_ff;
      aoc_pkg::IDX_AC_THR:    rdata = ac_thr_ff;
      aoc_pkg::IDX_TOT_THR:   rdata = tot_thr_ff;
      aoc_pkg::IDX_NOTCH_THR: rdata = notch_thr_ff;
      aoc_pkg::IDX_INIT_CORR: rdata = init_corr_ff;
      aoc_pkg::IDX_STATUS:    rdata = {23'h00_0000, waking_ff, pwr_state_ff,
                                       perf_done_ff & tracking, notch_hot_ff,
                                       tot_ok_ff, ac_ok_ff, eng_code};
      aoc_pkg::IDX_LEVELS:    rdata = {4'h0, tot_lvl_ff, 4'h0, ac_lvl_ff};
      aoc_pkg::IDX_CORR:      rdata = {8'h00, c_tim_ff, c_gain_ff, c_off_ff};
      aoc_pkg::IDX_NOTCH_LVL: rdata = {20'h0_0000, notch_lvl_ff};
      default:                rdata = 32'h0000_0000;
    endcase
    if (!aligned)
      rdata = 32'h0000_0000;
  end

  // zero-wait slave: answer registered during setup, valid in the access cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rdata : 32'h0000_0000;
    end
  end
endmodule : aoc_ctrl
`default_nettype wire

// ==== verif/aoc_ctrl_properties.sv ====
// port-level assertions for the adc output and correction control block
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl_props (
  // clock, reset and apb
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // output bus
  input wire logic        data_oe_n_out,
  input wire logic        output_data_clock_out,
  input wire logic        output_data_clock_oe_n_out,
  input wire logic        over_range_oe_n_out,
  input wire logic        cmos_mode_out,
  input wire logic        lvds_low_current_out,
  input wire logic        notch_powered_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic setup;
  logic wr_cfg;
  logic wr_eng;
  assign setup  = psel_in && !penable_in;
  assign wr_cfg = psel_in && penable_in && pwrite_in && paddr_in == 12'h1CC;
  assign wr_eng = psel_in && penable_in && pwrite_in && paddr_in == 12'h1D4;
  a_ready_next: assert property (setup |=> pready_out)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_idle_rdata: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside access");
  a_bad_align: assert property (setup && paddr_in[1:0] != 2'b00 |=> pslverr_out)
    else $error("unaligned access accepted");
  a_clk_half: assert property (!output_data_clock_oe_n_out |=>
    output_data_clock_out != $past(output_data_clock_out))
    else $error("output clock did not toggle");
  a_float_all: assert property (data_oe_n_out == output_data_clock_oe_n_out
    && data_oe_n_out == over_range_oe_n_out)
    else $error("outputs not floated together");
  a_cmos_cfg: assert property (wr_cfg |-> ##2 cmos_mode_out == $past(pwdata_in[4], 2))
    else $error("cmos mode not from config");
  a_lowi_cfg: assert property (wr_cfg |-> ##2
    lvds_low_current_out == $past(pwdata_in[5], 2))
    else $error("drive current not from config");
  a_notch_pwr: assert property (wr_eng |-> ##2
    notch_powered_out == !$past(pwdata_in[1], 2))
    else $error("notch power not from control");
  c_cfg: cover property (wr_cfg);
  c_err: cover property (pslverr_out);
  c_float: cover property ($rose(data_oe_n_out));
endmodule : aoc_ctrl_props
bind aoc_ctrl aoc_ctrl_props chk_u (.*);
`default_nettype wire

// ==== verif/aoc_rx_model.sv ====
// capture receiver that rebuilds words from the ddr halves
`timescale 1ns/1ps
`default_nettype none
module aoc_rx_model (
  input wire logic        clk_in,
  input wire logic [5:0]  data_in,
  input wire logic        dclk_in,
  input wire logic        oe_n_in,
  output logic     [11:0] word_out
);
  // a floated bus is ignored, so the last good word stays visible
  always_ff @(posedge clk_in)
  begin
    if (!oe_n_in && dclk_in)
      word_out[5:0] <= data_in;
    if (!oe_n_in && !dclk_in)
      word_out[11:6] <= data_in;
  end
endmodule : aoc_rx_model
`default_nettype wire

// ==== verif/aoc_ctrl_bench.sv ====
// self-checking bench for the control block
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl_bench;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in, sample_in, rx;
  logic [31:0] pwdata_in, prdata_out, r;
  logic sample_valid_in, over_range_in, clock_lost_in, e;
  logic power_state_select_pin_high_in, power_state_select_pin_low_in;
  logic [5:0] data_out;
  logic data_oe_n_out, output_data_clock_out, output_data_clock_oe_n_out;
  logic over_range_out, over_range_oe_n_out, cmos_mode_out, lvds_low_current_out;
  logic [7:0] corr_offset_out, corr_gain_out, corr_timing_out;
  logic notch_powered_out, perf_ok_out;
  int num_errors = 0;
  int n_tests = 0;
  aoc_ctrl #(.RELOCK_CYCLES(20), .PERF_CYCLES(32'h0000_0032)) dut_u (.*);
  aoc_rx_model rx_u (.clk_in(clk_in), .data_in(data_out), .dclk_in(output_data_clock_out),
    .oe_n_in(data_oe_n_out), .word_out(rx));
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, idx, 2'b00, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task t_reset;
    apb(0, aoc_pkg::IDX_OUT_CFG, 0);
    chk("cfg reset", aoc_pkg::RST_OUT_CFG, r);
    apb(0, aoc_pkg::IDX_STATUS, 0);
    chk("engine off", aoc_pkg::ENG_OFF, r[1:0]);
    chk("notch on", 1, notch_powered_out);
    apb(0, 10'h0FF, 0);
    chk("unmapped err", 1, e);
    apb(1, aoc_pkg::IDX_ENG_CTL, 32'h0000_0002);
    repeat (3) @(posedge clk_in);
    chk("notch off", 0, notch_powered_out);
  endtask : t_reset
  task t_coding;
    logic [11:0] s, x;
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 3; k++)
      begin
        apb(1, aoc_pkg::IDX_OUT_CFG, c | (c << 4));
        s = (k == 0) ? 12'h000 : (k == 1) ? 12'h800 : 12'hFFF;
        x = (c == 0) ? s : (c == 1) ? {~s[11], s[10:0]} : s ^ (s >> 1);
        @(posedge clk_in);
        {sample_in, sample_valid_in, over_range_in} <= {s, 1'b1, k == 2};
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("coded word", x, rx);
        chk("or", k == 2, over_range_out);
        chk("cmos", c[0], cmos_mode_out);
        chk("low drive", c[1], lvds_low_current_out);
      end
  endtask : t_coding
  task t_pin(input logic hi, input logic lo, input logic [1:0] st, input logic oe);
    @(posedge clk_in);
    {power_state_select_pin_high_in, power_state_select_pin_low_in} <= {hi, lo};
    repeat (aoc_pkg::WAKE_CYC + 12) @(posedge clk_in);
    chk("float", oe, data_oe_n_out);
    apb(0, aoc_pkg::IDX_STATUS, 0);
    chk("pin state", st, r[7:6]);
  endtask : t_pin
  task t_override;
    apb(1, aoc_pkg::IDX_PWR_CTL, aoc_pkg::PWR_NAP);
    t_pin(0, 1, aoc_pkg::PWR_NAP, 1);
    apb(1, aoc_pkg::IDX_PWR_CTL, aoc_pkg::PWR_NORMAL);
    t_pin(1, 0, aoc_pkg::PWR_NORMAL, 0);
  endtask : t_override
  task t_engine;
    apb(1, aoc_pkg::IDX_INIT_CORR, 32'h0003_0201);
    apb(1, aoc_pkg::IDX_ENG_CTL, 32'h0000_0003);
    apb(0, aoc_pkg::IDX_STATUS, 0);
    chk("hold", 2'h2, r[1:0]);
    chk("corr", 24'h03_0201, {corr_timing_out, corr_gain_out, corr_offset_out});
    for (int i = 0; i < 320; i++)
    begin
      @(posedge clk_in);
      {sample_in, sample_valid_in} <= {i[0] ? 12'hFFF : 12'h000, 1'b1};
      @(posedge clk_in);
      sample_valid_in <= 1'b0;
    end
    apb(0, aoc_pkg::IDX_STATUS, 0);
    chk("track", 2'h1, r[1:0]);
    chk("perf", 1, perf_ok_out);
  endtask : t_engine
  initial
  begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 0;
    {sample_in, sample_valid_in, over_range_in, clock_lost_in} = 0;
    {power_state_select_pin_high_in, power_state_select_pin_low_in} = 2'b01;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    t_reset();
    t_coding();
    t_pin(1, 0, aoc_pkg::PWR_NAP, 1);
    t_pin(0, 0, aoc_pkg::PWR_SLEEP, 1);
    t_pin(0, 1, aoc_pkg::PWR_NORMAL, 0);
    t_override();
    t_engine();
    print_verdict();
  end
endmodule : aoc_ctrl_bench
`default_nettype wire
